// File: hrs_defines.svh
// constants for the host register slave port
`ifndef HRS_DEFINES_SVH
`define HRS_DEFINES_SVH
`define HRS_SEL_W        4
`define HRS_DATA_W       8
`define HRS_CNT_W        4
`define HRS_SYNC_CYCLES  4'h2
`define HRS_SEL_IDLE     4'h0
`define HRS_DATA_IDLE    8'hff
`endif

// File: hrs_pkg.sv
// types shared by both ends of the host register slave port
`include "hrs_defines.svh"
package hrs_pkg;
    typedef logic [`HRS_SEL_W-1:0]  hrs_sel_t;
    typedef logic [`HRS_DATA_W-1:0] hrs_data_t;
    typedef logic [`HRS_CNT_W-1:0]  hrs_cnt_t;
    typedef enum logic [2:0] {
        DV_IDLE = 3'b000,
        DV_SYNC = 3'b001,
        DV_HOLD = 3'b010,
        DV_XFER = 3'b011,
        DV_LOAD = 3'b100,
        DV_ACK  = 3'b101
    } hrs_dev_state_t;
    typedef enum logic [2:0] {
        HS_IDLE  = 3'b000,
        HS_ADDR  = 3'b001,
        HS_LATCH = 3'b010,
        HS_STRB  = 3'b011,
        HS_DATA  = 3'b100,
        HS_REL   = 3'b101
    } hrs_host_state_t;
endpackage : hrs_pkg

// File: hrs_bus_if.sv
// pins between the host cpu and the register slave port
`timescale 1ns/1ps
`include "hrs_defines.svh"
interface hrs_bus_if;
    import hrs_pkg::*;
    logic      cs_n;
    logic      slave_read_strobe_n;
    logic      slave_write_strobe_n;
    hrs_sel_t  register_select_lines;
    logic      address_latch_strobe;
    logic      ack_n;
    hrs_data_t host_dout;
    logic      host_oe;
    hrs_data_t dev_dout;
    logic      dev_oe;
    hrs_data_t data;

    // undriven bus reads as all ones, as a pulled-up wire would
    assign data = dev_oe ? dev_dout : (host_oe ? host_dout : `HRS_DATA_IDLE);

    modport device (
        input  cs_n, slave_read_strobe_n, slave_write_strobe_n,
        input  register_select_lines, address_latch_strobe, data,
        output ack_n, dev_dout, dev_oe
    );
    modport host (
        output cs_n, slave_read_strobe_n, slave_write_strobe_n,
        output register_select_lines, address_latch_strobe, host_dout, host_oe,
        input  ack_n, data
    );
endinterface : hrs_bus_if

// File: hrs_device.sv
// device end: byte-wide register slave with acknowledge stretching
`timescale 1ns/1ps
`include "hrs_defines.svh"
module hrs_device #(
    parameter hrs_pkg::hrs_cnt_t SYNC_CYCLES = `HRS_SYNC_CYCLES
) (
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    hrs_bus_if.device              bus,
    input  wire logic              local_dma_busy,
    input  wire logic              remote_dma_busy,
    input  wire hrs_pkg::hrs_data_t reg_rdata,
    output logic                   reg_rd,
    output logic                   reg_wr,
    output hrs_pkg::hrs_sel_t      reg_addr,
    output hrs_pkg::hrs_data_t     reg_wdata,
    output logic                   slave_active
);
    import hrs_pkg::*;

    hrs_dev_state_t state_reg;
    hrs_dev_state_t state_next;
    hrs_cnt_t       sync_cnt_reg;
    hrs_sel_t       sel_latch_reg;
    logic           is_write_reg;
    logic           ack_n_reg;
    logic           dev_oe_reg;
    hrs_data_t      dev_dout_reg;
    logic           reg_rd_reg;
    logic           reg_wr_reg;
    hrs_sel_t       reg_addr_reg;
    hrs_data_t      reg_wdata_reg;
    logic           slave_active_reg;

    logic      rd_req;
    logic      wr_req;
    logic      access;
    logic      master_busy;
    hrs_sel_t  sel_eff;

    // slave only while chip select low
    assign rd_req = !bus.cs_n && !bus.slave_read_strobe_n;
    // write needs select and write strobe
    assign wr_req = !bus.cs_n && !bus.slave_write_strobe_n;
    // whichever edge comes last starts access
    assign access = rd_req || wr_req;
    // any running dma delays the answer
    assign master_busy = local_dma_busy || remote_dma_busy;

    // strobe high lets the select flow through
    assign sel_eff = bus.address_latch_strobe ? bus.register_select_lines : sel_latch_reg;

    // hold select once latch strobe falls
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            sel_latch_reg <= `HRS_SEL_IDLE;
        else if (bus.address_latch_strobe)
            sel_latch_reg <= bus.register_select_lines;
    end

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            DV_IDLE:
            begin
                if (access)
                    state_next = DV_SYNC;
            end
            DV_SYNC:
            begin
                // an access withdrawn before the array transfer is dropped unserved
                if (!access)
                    state_next = DV_IDLE;
                else if (sync_cnt_reg >= SYNC_CYCLES)
                    state_next = DV_HOLD;
            end
            DV_HOLD:
            begin
                if (!access)
                    state_next = DV_IDLE;
                else if (!master_busy)
                    state_next = DV_XFER;
            end
            DV_XFER:
            begin
                state_next = DV_LOAD;
            end
            DV_LOAD:
            begin
                state_next = DV_ACK;
            end
            DV_ACK:
            begin
                // release when active strobe goes away
                if (is_write_reg ? !wr_req : !rd_req)
                    state_next = DV_IDLE;
            end
            default:
            begin
                state_next = DV_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            state_reg <= DV_IDLE;
        else
            state_reg <= state_next;
    end

    // count system clock cycles since access start
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            sync_cnt_reg <= '0;
        else if (state_reg == DV_IDLE)
            sync_cnt_reg <= 4'h1;
        else if (state_reg == DV_SYNC && sync_cnt_reg < SYNC_CYCLES)
            sync_cnt_reg <= sync_cnt_reg + 4'h1;
    end

    // direction is frozen at start so a late second strobe cannot flip it
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            is_write_reg <= 1'b0;
        else if (state_reg == DV_IDLE && access)
            is_write_reg <= wr_req && !rd_req;
    end

    // one byte moved to or from the array
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            reg_rd_reg    <= 1'b0;
            reg_wr_reg    <= 1'b0;
            reg_addr_reg  <= `HRS_SEL_IDLE;
            reg_wdata_reg <= '0;
        end
        else
        begin
            reg_rd_reg <= 1'b0;
            reg_wr_reg <= 1'b0;
            if (state_reg == DV_HOLD && state_next == DV_XFER)
            begin
                reg_addr_reg <= sel_eff;
                reg_rd_reg   <= !is_write_reg;
                reg_wr_reg   <= is_write_reg;
                if (is_write_reg)
                    reg_wdata_reg <= bus.data;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            ack_n_reg <= 1'b1;
        else if (state_reg == DV_LOAD)
            ack_n_reg <= 1'b0;
        else if (state_reg == DV_ACK && state_next == DV_IDLE)
            ack_n_reg <= 1'b1;
    end

    // read data is valid from the acknowledge edge; array answers a cycle after reg_rd
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            dev_oe_reg   <= 1'b0;
            dev_dout_reg <= `HRS_DATA_IDLE;
        end
        else if (state_reg == DV_LOAD && !is_write_reg)
        begin
            dev_oe_reg   <= 1'b1;
            dev_dout_reg <= reg_rdata;
        end
        else if (state_next == DV_IDLE)
        begin
            dev_oe_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            slave_active_reg <= 1'b0;
        else
            slave_active_reg <= !bus.cs_n;
    end

    assign bus.ack_n    = ack_n_reg;
    assign bus.dev_oe   = dev_oe_reg;
    assign bus.dev_dout = dev_dout_reg;
    assign reg_rd       = reg_rd_reg;
    assign reg_wr       = reg_wr_reg;
    assign reg_addr     = reg_addr_reg;
    assign reg_wdata    = reg_wdata_reg;
    assign slave_active = slave_active_reg;
endmodule : hrs_device

// File: hrs_host.sv
// host end: cpu bus logic issuing byte register accesses
`timescale 1ns/1ps
`include "hrs_defines.svh"
module hrs_host #(
    parameter bit MUX_BUS = 1'b0
) (
    input  wire logic               clk_sys,
    input  wire logic               rstn,
    hrs_bus_if.host                 bus,
    input  wire logic               cmd_valid,
    input  wire logic               cmd_write,
    input  wire hrs_pkg::hrs_sel_t  cmd_sel,
    input  wire hrs_pkg::hrs_data_t cmd_wdata,
    output logic                    cmd_ready,
    output logic                    rsp_valid,
    output hrs_pkg::hrs_data_t      rsp_rdata
);
    import hrs_pkg::*;

    hrs_host_state_t state_reg;
    logic            cs_n_reg;
    logic            rd_n_reg;
    logic            wr_n_reg;
    hrs_sel_t        sel_reg;
    logic            als_reg;
    logic            oe_reg;
    hrs_data_t       dout_reg;
    logic            write_reg;
    logic            ready_reg;
    logic            rsp_valid_reg;
    hrs_data_t       rsp_rdata_reg;

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            state_reg     <= HS_IDLE;
            cs_n_reg      <= 1'b1;
            rd_n_reg      <= 1'b1;
            wr_n_reg      <= 1'b1;
            sel_reg       <= `HRS_SEL_IDLE;
            als_reg       <= 1'b1;
            oe_reg        <= 1'b0;
            dout_reg      <= `HRS_DATA_IDLE;
            write_reg     <= 1'b0;
            ready_reg     <= 1'b0;
            rsp_valid_reg <= 1'b0;
            rsp_rdata_reg <= '0;
        end
        else
        begin
            rsp_valid_reg <= 1'b0;
            case (state_reg)
                HS_IDLE:
                begin
                    ready_reg <= 1'b1;
                    if (cmd_valid && ready_reg)
                    begin
                        ready_reg <= 1'b0;
                        write_reg <= cmd_write;
                        dout_reg  <= cmd_wdata;
                        // select loaded here while strobe is still high
                        sel_reg   <= cmd_sel;
                        state_reg <= MUX_BUS ? HS_ADDR : HS_STRB;
                    end
                end
                HS_ADDR:
                begin
                    // pulse latch strobe low over the select
                    als_reg   <= 1'b0;
                    state_reg <= HS_LATCH;
                end
                HS_LATCH:
                begin
                    // lines turn to data on a shared bus, so select is no longer held
                    sel_reg   <= `HRS_SEL_IDLE;
                    state_reg <= HS_STRB;
                    cs_n_reg  <= 1'b0;
                    rd_n_reg  <= write_reg;
                    wr_n_reg  <= !write_reg;
                    oe_reg    <= write_reg;
                end
                HS_STRB:
                begin
                    cs_n_reg <= 1'b0;
                    rd_n_reg <= write_reg;
                    wr_n_reg <= !write_reg;
                    oe_reg   <= write_reg;
                    if (!bus.ack_n && !cs_n_reg)
                        state_reg <= HS_DATA;
                end
                HS_DATA:
                begin
                    rsp_rdata_reg <= write_reg ? dout_reg : bus.data;
                    cs_n_reg  <= 1'b1;
                    rd_n_reg  <= 1'b1;
                    wr_n_reg  <= 1'b1;
                    oe_reg    <= 1'b0;
                    state_reg <= HS_REL;
                end
                HS_REL:
                begin
                    // next access only after acknowledge returns high
                    if (bus.ack_n)
                    begin
                        als_reg       <= 1'b1;
                        rsp_valid_reg <= 1'b1;
                        state_reg     <= HS_IDLE;
                    end
                end
                default:
                begin
                    state_reg <= HS_IDLE;
                end
            endcase
        end
    end

    assign bus.cs_n                  = cs_n_reg;
    assign bus.slave_read_strobe_n   = rd_n_reg;
    assign bus.slave_write_strobe_n  = wr_n_reg;
    assign bus.register_select_lines = sel_reg;
    assign bus.address_latch_strobe  = als_reg;
    assign bus.host_oe               = oe_reg;
    assign bus.host_dout             = dout_reg;
    assign cmd_ready                 = ready_reg;
    assign rsp_valid                 = rsp_valid_reg;
    assign rsp_rdata                 = rsp_rdata_reg;
endmodule : hrs_host

// File: hrs_bus_asserts.sv
// assertions on the wires between the host and device ends
`timescale 1ns/1ps
`include "hrs_defines.svh"
module hrs_bus_asserts #(
    parameter hrs_pkg::hrs_cnt_t SYNC_CYCLES = `HRS_SYNC_CYCLES
) (
    input wire logic               clk_sys,
    input wire logic               rstn,
    input wire logic               cs_n,
    input wire logic               slave_read_strobe_n,
    input wire logic               slave_write_strobe_n,
    input wire hrs_pkg::hrs_sel_t  register_select_lines,
    input wire logic               address_latch_strobe,
    input wire logic               ack_n,
    input wire logic               dev_oe
);
    import hrs_pkg::*;
    logic       acc;
    logic [7:0] wait_reg;
    assign acc = !cs_n && !(slave_read_strobe_n && slave_write_strobe_n);
    // saturating count of cycles the open access has waited
    always_ff @(posedge clk_sys)
    begin
        if (!rstn || !acc)
            wait_reg <= 8'h00;
        else if (ack_n && wait_reg != 8'hff)
            wait_reg <= wait_reg + 8'h01;
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    sequence s_ack_fall;
        $fell(ack_n);
    endsequence
    sequence s_released;
        !ack_n && slave_read_strobe_n && slave_write_strobe_n;
    endsequence
    AST_ACK_CAUSE: assert property (s_ack_fall |-> acc)
        else $error("acknowledge without a selected strobe");
    // counter runs from the start edge, so the fastest answer shows sync plus four
    AST_ACK_SYNC: assert property (s_ack_fall |-> wait_reg >= 8'(SYNC_CYCLES) + 8'h04)
        else $error("acknowledge before synchronization");
    AST_ACK_DROP: assert property (s_released |=> ack_n)
        else $error("acknowledge kept after strobe release");
    AST_ACK_HOLD: assert property (!ack_n && acc |=> !ack_n)
        else $error("acknowledge dropped while strobe held");
    AST_RD_DRIVE: assert property (!ack_n && acc && !slave_read_strobe_n |-> dev_oe)
        else $error("read acknowledged without data drive");
    AST_WR_QUIET: assert property (!slave_write_strobe_n |-> !dev_oe)
        else $error("device drives data during a write");
    AST_IDLE: assert property (cs_n [*2] |-> ack_n && !dev_oe)
        else $error("device active while deselected");
    AST_HOST_WAIT: assert property (acc && ack_n |=> acc)
        else $error("host left access before acknowledge");
    AST_CS_LAST: assert property ($rose(cs_n) |-> slave_read_strobe_n && slave_write_strobe_n)
        else $error("chip select released before strobe");
    AST_SEL_OPEN: assert property (!$stable(register_select_lines) |-> address_latch_strobe && !acc)
        else $error("select changed while latched or in access");
endmodule : hrs_bus_asserts

// File: host_register_slave_port_test.sv
// bench: host end against device end, a multiplexed pair, and a device driven pin by pin
`timescale 1ns/1ps
`include "hrs_defines.svh"
module host_register_slave_port_test;
    import hrs_pkg::*;
    localparam hrs_cnt_t SYNC = 4'h2;
    logic      clk_sys, rstn, cmd_valid, cmd_write, cmd_ready, rsp_valid;
    logic      dma_l, dma_r, reg_rd, reg_wr, rd2, wr2;
    hrs_sel_t  cmd_sel, reg_addr, addr2;
    hrs_data_t cmd_wdata, rsp_rdata, reg_rdata, reg_wdata, wdata2, rd, mem [16];
    int        err_count = 0, tests_run = 0, cyc = 0, wr_cnt = 0, rd_cnt = 0, rd2_cnt = 0;
    int        n, t0;
    logic      cmd_valid3, rsp_valid3, sa2;
    hrs_sel_t  addr3;
    hrs_data_t rsp_rdata3;
    hrs_bus_if bus ();
    hrs_bus_if bus2 ();
    hrs_bus_if bus3 ();
    hrs_device #(.SYNC_CYCLES(SYNC)) hrs_device_i (.clk_sys(clk_sys), .rstn(rstn), .bus(bus),
        .local_dma_busy(dma_l), .remote_dma_busy(dma_r), .reg_rdata(reg_rdata),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .slave_active());
    hrs_device #(.SYNC_CYCLES(SYNC)) hrs_device_i2 (.clk_sys(clk_sys), .rstn(rstn), .bus(bus2),
        .local_dma_busy(1'b0), .remote_dma_busy(1'b0), .reg_rdata(8'h3c),
        .reg_rd(rd2), .reg_wr(wr2), .reg_addr(addr2), .reg_wdata(wdata2), .slave_active(sa2));
    hrs_device #(.SYNC_CYCLES(SYNC)) hrs_device_i3 (.clk_sys(clk_sys), .rstn(rstn), .bus(bus3),
        .local_dma_busy(1'b0), .remote_dma_busy(1'b0), .reg_rdata(8'h5a),
        .reg_rd(), .reg_wr(), .reg_addr(addr3), .reg_wdata(), .slave_active());
    hrs_host #(.MUX_BUS(1'b1)) hrs_host_i3 (.clk_sys(clk_sys), .rstn(rstn), .bus(bus3),
        .cmd_valid(cmd_valid3), .cmd_write(cmd_write), .cmd_sel(cmd_sel),
        .cmd_wdata(cmd_wdata), .cmd_ready(), .rsp_valid(rsp_valid3),
        .rsp_rdata(rsp_rdata3));
    hrs_host #(.MUX_BUS(1'b0)) hrs_host_i (.clk_sys(clk_sys), .rstn(rstn), .bus(bus),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_sel(cmd_sel),
        .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata));
    hrs_bus_asserts #(.SYNC_CYCLES(SYNC)) hrs_bus_asserts_i (.clk_sys(clk_sys), .rstn(rstn),
        .cs_n(bus.cs_n), .slave_read_strobe_n(bus.slave_read_strobe_n),
        .slave_write_strobe_n(bus.slave_write_strobe_n),
        .register_select_lines(bus.register_select_lines),
        .address_latch_strobe(bus.address_latch_strobe), .ack_n(bus.ack_n),
        .dev_oe(bus.dev_oe));

    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // register array behind the first device, one cycle read latency
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (reg_wr === 1'b1)
            mem[reg_addr] <= reg_wdata;
        if (reg_rd === 1'b1)
            reg_rdata <= mem[reg_addr];
        wr_cnt <= wr_cnt + int'(reg_wr === 1'b1);
        rd_cnt <= rd_cnt + int'(reg_rd === 1'b1);
        rd2_cnt <= rd2_cnt + int'(rd2 === 1'b1);
    end

    task automatic check(input hrs_data_t seen, input hrs_data_t exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop;
        if (err_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop

    // one byte command through the host end, response left in rd
    task automatic access(input logic w, input hrs_sel_t s, input hrs_data_t d);
        int k;
        k = 0;
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_sel <= s;
        cmd_wdata <= d;
        do
            @(negedge clk_sys);
        while (cmd_ready !== 1'b1 && ++k < 200);
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        do
            @(negedge clk_sys);
        while (rsp_valid !== 1'b1 && ++k < 400);
        if (rsp_valid !== 1'b1)
        begin
            err_count++;
            $display("BAD %0t no response from host end", $time);
        end
        rd = rsp_rdata;
    endtask : access

    task automatic pins2(input logic c, input logic r, input logic w, input logic a,
                         input hrs_sel_t s);
        @(posedge clk_sys);
        bus2.cs_n <= c;
        bus2.slave_read_strobe_n <= r;
        bus2.slave_write_strobe_n <= w;
        bus2.address_latch_strobe <= a;
        bus2.register_select_lines <= s;
    endtask : pins2

    task automatic wait_ack2;
        n = 0;
        do
        begin
            @(negedge clk_sys);
            n++;
        end
        while (bus2.ack_n !== 1'b0 && n < 100);
    endtask : wait_ack2

    initial
    begin
        {cmd_valid3, cmd_valid, cmd_write, dma_l, dma_r, rstn} = 6'h00;
        cmd_sel = 4'h0;
        cmd_wdata = 8'h00;
        reg_rdata = 8'h00;
        {bus2.cs_n, bus2.slave_read_strobe_n, bus2.slave_write_strobe_n} = 3'h7;
        bus2.address_latch_strobe = 1'b1;
        bus2.register_select_lines = 4'h0;
        bus2.host_oe = 1'b0;
        bus2.host_dout = 8'h00;
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        for (int i = 0; i < 16; i++)
            access(1'b1, hrs_sel_t'(i), hrs_data_t'(i) * 8'h25 + 8'h05);
        for (int i = 0; i < 16; i++)
        begin
            access(1'b0, hrs_sel_t'(i), 8'h00);
            check(rd, hrs_data_t'(i) * 8'h25 + 8'h05);
        end
        check(8'(wr_cnt), 8'h10);
        check(8'(rd_cnt), 8'h10);
        // local then remote dma stalls the read
        for (int k = 0; k < 2; k++)
        begin
            t0 = cyc;
            fork
                access(1'b0, 4'h7, 8'h00);
                begin
                    @(posedge clk_sys);
                    {dma_l, dma_r} <= (k == 0) ? 2'h2 : 2'h1;
                    repeat (30) @(posedge clk_sys);
                    {dma_l, dma_r} <= 2'h0;
                end
            join
            check(8'(cyc - t0 > 30), 8'h01);
            check(rd, 8'h08);
        end
        // multiplexed host end: select latched, lines then cleared a cycle after the strobe falls
        @(posedge clk_sys);
        cmd_valid3 <= 1'b1;
        cmd_write <= 1'b0;
        cmd_sel <= 4'hb;
        @(posedge clk_sys);
        cmd_valid3 <= 1'b0;
        n = 0;
        do
            @(negedge clk_sys);
        while (rsp_valid3 !== 1'b1 && ++n < 100);
        check(rsp_rdata3, 8'h5a);
        check({4'h0, addr3}, 8'h0b);
        // chip select arrives after the read strobe
        pins2(1'b1, 1'b0, 1'b1, 1'b1, 4'h9);
        repeat (3) @(posedge clk_sys);
        pins2(1'b0, 1'b0, 1'b1, 1'b1, 4'h9);
        wait_ack2;
        check(8'(n), 8'(SYNC) + 8'h05);
        check(bus2.data, 8'h3c);
        check({4'h0, addr2}, 8'h09);
        check({7'h00, sa2}, 8'h01);
        pins2(1'b1, 1'b1, 1'b1, 1'b1, 4'h9);
        repeat (2) @(negedge clk_sys);
        check({7'h00, bus2.ack_n}, 8'h01);
        check({7'h00, sa2}, 8'h00);
        check(bus2.data, `HRS_DATA_IDLE);
        // select latched, then the lines change before the write
        pins2(1'b1, 1'b1, 1'b1, 1'b1, 4'h5);
        pins2(1'b1, 1'b1, 1'b1, 1'b0, 4'ha);
        bus2.host_oe <= 1'b1;
        bus2.host_dout <= 8'h6e;
        pins2(1'b0, 1'b1, 1'b0, 1'b0, 4'ha);
        wait_ack2;
        check(8'(n), 8'(SYNC) + 8'h05);
        check({4'h0, addr2}, 8'h05);
        check(wdata2, 8'h6e);
        pins2(1'b1, 1'b1, 1'b1, 1'b1, 4'ha);
        bus2.host_oe <= 1'b0;
        // read withdrawn before the acknowledge moves nothing
        t0 = rd2_cnt;
        pins2(1'b0, 1'b0, 1'b1, 1'b1, 4'h2);
        pins2(1'b1, 1'b1, 1'b1, 1'b1, 4'h2);
        repeat (12) @(negedge clk_sys);
        check(8'(rd2_cnt - t0), 8'h00);
        check({7'h00, bus2.ack_n}, 8'h01);
        report_and_stop;
    end

    // hang guard, well beyond the few dozen accesses above
    initial
    begin
        repeat (8000) @(posedge clk_sys);
        err_count++;
        $display("BAD %0t watchdog expired", $time);
        report_and_stop;
    end
endmodule : host_register_slave_port_test
